/* File: common/lbpp_defs.svh */
// Offsets, field positions and timing counts of the parallel line buffer port.
// Behaviour
// - Sender strobe lasts at least 0.5 us.
// - Data lines positive logic, high means one.
// - Data 6 or Data 7 set means printable.
// - Data 6 and 7 clear means control.
// - Accepted character answered by low acknowledge pulse.
// - Busy high whenever data cannot be received.
// - Paper-out output high while out of paper.
// - Online-select output high while selected online.
// - Free-running 125 kHz auxiliary clock output.
// - Low remote stop ends form or tab motion.
// - Fault output low while fault exists.
// - Line-count contact pulses once per line feed.
// - Strobes after acknowledge stored, spaced 11.5 us.
// - Gated strobe discards while busy, except offline.
// - Gated offline busy accepts, acts only on DC1.
// - Busy on 132 printables or terminator code.
// - Line busy clears on empty FIFO or print.
// - Busy at 249 stored, released at 121.
// - Busy on encoder error, paper-out or offline.
`ifndef LBPP_DEFS_SVH
`define LBPP_DEFS_SVH

`define LBPP_CLK_MHZ          125
`define LBPP_STROBE_NS        500
`define LBPP_INTERVAL_NS      11500
`define LBPP_ACK_NS           2000
`define LBPP_LINE_PULSE_NS    20000
`define LBPP_AUX_CLK_KHZ      125
`define LBPP_STROBE_CYCLES    ((`LBPP_STROBE_NS * `LBPP_CLK_MHZ + 999) / 1000)
`define LBPP_INTERVAL_CYCLES  ((`LBPP_INTERVAL_NS * `LBPP_CLK_MHZ + 999) / 1000)
`define LBPP_ACK_CYCLES       ((`LBPP_ACK_NS * `LBPP_CLK_MHZ + 999) / 1000)
`define LBPP_LINE_CYCLES      ((`LBPP_LINE_PULSE_NS * `LBPP_CLK_MHZ + 999) / 1000)
`define LBPP_AUX_HALF_CYCLES  ((`LBPP_CLK_MHZ * 1000) / (2 * `LBPP_AUX_CLK_KHZ))

`define LBPP_FIFO_DEPTH       9'h100
`define LBPP_LINE_CHARS       8'h84
`define LBPP_FULL_SET         9'hf9
`define LBPP_FULL_CLEAR       9'h79
`define LBPP_CODE_DEL         8'h7f
`define LBPP_CODE_LF          8'h0a
`define LBPP_CODE_VT          8'h0b
`define LBPP_CODE_FF          8'h0c
`define LBPP_CODE_CR          8'h0d
`define LBPP_CODE_DC1         8'h11

`define LBPP_DEV_CTRL         8'h00
`define LBPP_DEV_CMD          8'h04
`define LBPP_DEV_STATUS       8'h08
`define LBPP_DEV_FIFO         8'h0c
`define LBPP_DEV_IRQ_STATUS   8'h10
`define LBPP_DEV_IRQ_MASK     8'h14
`define LBPP_CTRL_GATED       0
`define LBPP_CTRL_ONLINE      1
`define LBPP_CTRL_PAPER_OUT   2
`define LBPP_CTRL_ENC_ERROR   3
`define LBPP_CTRL_FAULT       4
`define LBPP_CMD_PRINT_BEGIN  0
`define LBPP_CMD_LINE_FEED    1
`define LBPP_CMD_FORM_START   2
`define LBPP_DEV_IRQ_WIDTH    4

`define LBPP_HOST_TXDATA      8'h00
`define LBPP_HOST_CTRL        8'h04
`define LBPP_HOST_STATUS      8'h08
`define LBPP_HOST_IRQ_STATUS  8'h0c
`define LBPP_HOST_IRQ_MASK    8'h10
`define LBPP_HCTRL_WAIT_READY 0
`define LBPP_HCTRL_STOP       1
`define LBPP_HOST_IRQ_WIDTH   4

`endif

/* File: common/lbpp_if.sv */
// Parallel cable between the sending host and the printer line buffer.
`timescale 1ns/1ps
interface lbpp_if;
  import lbpp_pkg::*;
  logic          strobeN;
  lbpp_char_type data;
  logic          ackN;
  logic          busy;
  logic          paperOut;
  logic          onlineSelect;
  logic          auxClockOut;
  logic          remoteMotionStopN;
  logic          faultN;
  logic          lineCount;

  modport printer (
    input  strobeN, data, remoteMotionStopN,
    output ackN, busy, paperOut, onlineSelect, auxClockOut, faultN, lineCount
  );
  modport host (
    output strobeN, data, remoteMotionStopN,
    input  ackN, busy, paperOut, onlineSelect, auxClockOut, faultN, lineCount
  );
endinterface : lbpp_if

/* File: common/lbpp_pkg.sv */
// Types shared by both ends of the parallel line buffer port.
package lbpp_pkg;
  typedef logic [7:0] lbpp_char_type;
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_WAIT_READY,
    HOST_STROBE,
    HOST_SPACE
  } lbpp_host_state_type;
endpackage : lbpp_pkg

/* File: tb/lbpp_props.sv */
// Concurrent checks on the cable between the host and printer ends.
`timescale 1ns/1ps
module lbpp_props (
  // System
  input wire logic                    clk_sys,
  input wire logic                    reset,
  // Cable
  input wire logic                    strobeN,
  input wire lbpp_pkg::lbpp_char_type data,
  input wire logic                    ackN,
  input wire logic                    busy,
  input wire logic                    auxClockOut,
  input wire logic                    lineCount
);
  import lbpp_pkg::*;
  // The line-count pulse is far longer than a repetition may reach, so its width is counted here.
  logic [11:0] highCount;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) highCount <= 12'h000;
    else highCount <= lineCount ? highCount + 12'h001 : 12'h000;
  end
  // The aux clock half period is too long for a plain delay, so the age of its level is counted.
  logic       auxPrev;
  logic [9:0] auxAge;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      auxPrev <= 1'b0;
      auxAge  <= 10'h000;
    end else begin
      auxPrev <= auxClockOut;
      auxAge  <= (auxClockOut != auxPrev) ? 10'h001 : auxAge + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_ackRelease; ##250 $rose(ackN); endsequence
  property p_strobeWidth; $fell(strobeN) |-> ##63 $rose(strobeN); endproperty
  property p_dataHeld; !strobeN && !$fell(strobeN) |-> $stable(data); endproperty
  // A strobe while busy may be discarded by the gated option, so only a ready printer must answer.
  property p_ackAnswer; $rose(strobeN) && !busy |-> ##[1:8] $fell(ackN); endproperty
  property p_ackWidth; $fell(ackN) |-> s_ackRelease; endproperty
  property p_readyAfterReset; $fell(reset) |=> !busy; endproperty
  property p_auxToggle; $changed(auxClockOut) |-> auxAge == 10'h1f4; endproperty
  property p_termBusy;
    $rose(strobeN) && (data inside {8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h7f}) |-> ##[1:8] busy;
  endproperty
  property p_lineWidth; $fell(lineCount) |-> highCount == 12'h9c4; endproperty
  a_strobeWidth: assert property (p_strobeWidth) else $error("strobe width wrong");
  a_dataHeld: assert property (p_dataHeld) else $error("data moved during strobe");
  a_ackAnswer: assert property (p_ackAnswer) else $error("no acknowledge");
  a_ackWidth: assert property (p_ackWidth) else $error("acknowledge width wrong");
  a_readyAfterReset: assert property (p_readyAfterReset) else $error("busy after reset");
  a_auxToggle: assert property (p_auxToggle) else $error("aux clock period wrong");
  a_termBusy: assert property (p_termBusy) else $error("no busy on terminator");
  a_lineWidth: assert property (p_lineWidth) else $error("line pulse width wrong");
endmodule : lbpp_props

/* File: tb/lbpp_test.sv */
// Self-checking bench joining the host and printer ends over one cable.
`timescale 1ns/1ps
module lbpp_test;
  import lbpp_pkg::*;
  logic        clk_sys, reset, pselH, pselP, penable, pwrite;
  logic        readyH, readyP, errH, errP, irqH, irqP, errv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdH, rdP, rdv;
  int          nMismatch, totalChecks;
  // Row layout: printable flag, busy expected, character.
  logic [9:0]  rows [10] = '{10'h241, 10'h220, 10'h240, 10'h01f, 10'h10a,
                             10'h10b, 10'h10c, 10'h10d, 10'h37f, 10'h080};
  lbpp_if cable ();
  lbpp_host lbpp_host_i (.clk_sys(clk_sys), .reset(reset), .psel(pselH), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(rdH), .pready(readyH), .pslverr(errH), .irq(irqH), .link(cable.host));
  lbpp_printer lbpp_printer_i (.clk_sys(clk_sys), .reset(reset), .psel(pselP), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rdP), .pready(readyP), .pslverr(errP),
    .irq(irqP), .link(cable.printer));
  lbpp_props lbpp_props_i (.clk_sys(clk_sys), .reset(reset), .strobeN(cable.strobeN), .data(cable.data),
    .ackN(cable.ackN), .busy(cable.busy), .auxClockOut(cable.auxClockOut), .lineCount(cable.lineCount));
  ////////////////////////////////////////////////////////////////////////////////
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      nMismatch++;
    end
  endtask : chk
  // Entered just after a rising edge; h selects the host end, otherwise the printer end.
  task automatic apb(input logic h, input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    pselH <= h;
    pselP <= !h;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((h ? readyH : readyP) !== 1'b1);
    rdv = h ? rdH : rdP;
    errv = h ? errH : errP;
    pselH <= 1'b0;
    pselP <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1);
    @(posedge clk_sys);
  endtask : apb
  // The wait keeps strobes at least the minimum interval apart.
  task automatic send(input logic [7:0] c);
    apb(1'b1, 8'h00, 1'b1, {24'h0, c});
    repeat (1440) @(posedge clk_sys);
  endtask : send
  task automatic tick2;
    repeat (2) @(posedge clk_sys);
  endtask : tick2
  task wrap_up;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    nMismatch++;
    wrap_up();
  end
  initial begin
    reset = 1'b1;
    {pselH, pselP, penable, pwrite, paddr, pwdata} = '0;
    nMismatch = 0;
    totalChecks = 0;
    repeat (4) @(posedge clk_sys);
    chk({cable.busy, cable.ackN, cable.strobeN}, 3'h7);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      send(rows[i][7:0]);
      chk(cable.busy, rows[i][8]);
      apb(1'b0, 8'h0c, 1'b0, 32'h0);
      chk(rdv, {22'h0, 1'b1, rows[i][9], rows[i][7:0]});
      tick2();
      chk(cable.busy, 1'b0);
    end
    send(8'h55);
    chk(irqP, 1'b0);
    apb(1'b0, 8'h14, 1'b1, 32'h1);
    tick2();
    chk(irqP, 1'b1);
    apb(1'b0, 8'h10, 1'b1, 32'h1);
    apb(1'b0, 8'h0c, 1'b0, 32'h0);
    chk(irqP, 1'b0);
    apb(1'b0, 8'h00, 1'b1, 32'h14);
    tick2();
    chk({cable.paperOut, cable.onlineSelect, cable.faultN, cable.busy}, 4'h9);
    apb(1'b0, 8'h00, 1'b1, 32'h1);
    send(8'h11);
    apb(1'b0, 8'h00, 1'b1, 32'h7);
    send(8'h42);
    apb(1'b0, 8'h10, 1'b0, 32'h0);
    chk(rdv[1], 1'b1);
    chk(rdv[3], 1'b1);
    apb(1'b0, 8'h08, 1'b0, 32'h0);
    chk(rdv[1], 1'b1);
    apb(1'b0, 8'h00, 1'b1, 32'h2);
    for (int h = 0; h < 2; h++) begin
      apb(h[0], 8'h40, 1'b0, 32'h0);
      chk(errv, 1'b1);
      chk(rdv, 32'h0);
    end
    apb(1'b0, 8'h00, 1'b1, 32'h0);
    apb(1'b1, 8'h04, 1'b1, 32'h1);
    send(8'h41);
    apb(1'b1, 8'h08, 1'b0, 32'h0);
    chk(rdv[1:0], 2'h3);
    apb(1'b0, 8'h00, 1'b1, 32'h2);
    repeat (1500) @(posedge clk_sys);
    apb(1'b0, 8'h08, 1'b0, 32'h0);
    chk(rdv[16:8], 9'h001);
    apb(1'b0, 8'h04, 1'b1, 32'h2);
    repeat (2600) @(posedge clk_sys);
    apb(1'b1, 8'h0c, 1'b0, 32'h0);
    chk(rdv[2], 1'b1);
    apb(1'b0, 8'h04, 1'b1, 32'h4);
    apb(1'b0, 8'h08, 1'b0, 32'h0);
    chk(rdv[2], 1'b1);
    apb(1'b1, 8'h04, 1'b1, 32'h2);
    tick2();
    chk(cable.remoteMotionStopN, 1'b0);
    tick2();
    apb(1'b0, 8'h08, 1'b0, 32'h0);
    chk(rdv[2], 1'b0);
    wrap_up();
  end
endmodule : lbpp_test

/* File: verilog/lbpp_host.sv */
// Host end: sends characters with a timed strobe and reports printer status over APB.
`timescale 1ns/1ps
`include "lbpp_defs.svh"
module lbpp_host (
  // System
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Interrupt
  output logic                     irq,
  // Cable
  lbpp_if.host                     link
);
  import lbpp_pkg::*;

  localparam logic [10:0] STROBE_CYCLES   = 11'(`LBPP_STROBE_CYCLES);
  localparam logic [10:0] INTERVAL_CYCLES = 11'(`LBPP_INTERVAL_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  lbpp_host_state_type              state;
  logic [1:0]                       ctrl;
  logic [`LBPP_HOST_IRQ_WIDTH-1:0]  irqStatus, irqMask, irqSet, irqClear;
  logic [10:0]                      timer;
  logic                             ackSeen, lineLast, paperLast;
  logic [5:0]                       pinMeta, pinSync;
  logic                             ackSync, busySync, paperSync, onlineSync, lineSync, faultSyncN;
  logic                             apbWrite, startSend, sendDone;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pinMeta <= 6'h21;
      pinSync <= 6'h21;
    end else begin
      pinMeta <= {link.faultN, link.lineCount, link.onlineSelect, link.paperOut, link.busy, link.ackN};
      pinSync <= pinMeta;
    end
  end
  assign {faultSyncN, lineSync, onlineSync, paperSync, busySync, ackSync} = pinSync;

  assign apbWrite  = psel & penable & pready & pwrite;
  assign startSend = apbWrite && paddr == `LBPP_HOST_TXDATA && state == HOST_IDLE;
  assign sendDone  = state == HOST_SPACE && timer == INTERVAL_CYCLES;

  ////////////////////////////////////////////////////////////////////////////
  // Send sequence: optional wait for ready, strobe, then hold off for the least interval.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state        <= HOST_IDLE;
      timer        <= 11'h000;
      ackSeen      <= 1'b0;
      link.strobeN <= 1'b1;
      link.data    <= 8'h00;
    end else begin
      unique case (state)
        HOST_IDLE: begin
          if (startSend) begin
            link.data <= pwdata[7:0];
            ackSeen   <= 1'b0;
            state     <= ctrl[`LBPP_HCTRL_WAIT_READY] ? HOST_WAIT_READY : HOST_STROBE;
            link.strobeN <= ctrl[`LBPP_HCTRL_WAIT_READY];
            timer     <= 11'h001;
          end
        end
        HOST_WAIT_READY: begin
          if (!busySync) begin
            state        <= HOST_STROBE;
            link.strobeN <= 1'b0;
            timer        <= 11'h001;
          end
        end
        HOST_STROBE: begin
          timer <= timer + 11'h001;
          if (timer == STROBE_CYCLES) begin
            link.strobeN <= 1'b1;
            state        <= HOST_SPACE;
          end
        end
        HOST_SPACE: begin
          timer <= timer + 11'h001;
          if (!ackSync) begin
            ackSeen <= 1'b1;
          end
          if (sendDone) begin
            state <= HOST_IDLE;
          end
        end
      endcase
    end
  end

  // The stop request is a level held for as long as software keeps the bit set.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      link.remoteMotionStopN <= 1'b1;
    end else begin
      link.remoteMotionStopN <= ~ctrl[`LBPP_HCTRL_STOP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt.
  assign irqSet   = {paperSync & ~paperLast, lineSync & ~lineLast,
                     sendDone & ~ackSeen & ackSync, sendDone};
  assign irqClear = (apbWrite && paddr == `LBPP_HOST_IRQ_STATUS) ?
                    pwdata[`LBPP_HOST_IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl      <= 2'h0;
      irqMask   <= '0;
      irqStatus <= '0;
      irq       <= 1'b0;
      lineLast  <= 1'b0;
      paperLast <= 1'b0;
    end else begin
      if (apbWrite && paddr == `LBPP_HOST_CTRL) begin
        ctrl <= pwdata[1:0];
      end
      if (apbWrite && paddr == `LBPP_HOST_IRQ_MASK) begin
        irqMask <= pwdata[`LBPP_HOST_IRQ_WIDTH-1:0];
      end
      lineLast  <= lineSync;
      paperLast <= paperSync;
      irqStatus <= (irqStatus & ~irqClear) | irqSet;
      irq       <= |(irqStatus & irqMask);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
        unique case (paddr)
          `LBPP_HOST_TXDATA:     prdata <= {24'h0, link.data};
          `LBPP_HOST_CTRL:       prdata <= {30'h0, ctrl};
          `LBPP_HOST_STATUS:     prdata <= {26'h0, ackSeen, ~faultSyncN, onlineSync, paperSync,
                                            busySync, state != HOST_IDLE};
          `LBPP_HOST_IRQ_STATUS: prdata <= {28'h0, irqStatus};
          `LBPP_HOST_IRQ_MASK:   prdata <= {28'h0, irqMask};
          default:               pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : lbpp_host

/* File: verilog/lbpp_printer.sv */
// Printer end: strobe capture, input FIFO, busy generation, status pins and APB registers.
`timescale 1ns/1ps
`include "lbpp_defs.svh"
module lbpp_printer (
  // System
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Interrupt
  output logic                     irq,
  // Cable
  lbpp_if.printer                  link
);
  import lbpp_pkg::*;

  localparam logic [9:0]  ACK_CYCLES  = 10'(`LBPP_ACK_CYCLES);
  localparam logic [11:0] LINE_CYCLES = 12'(`LBPP_LINE_CYCLES);
  localparam logic [9:0]  AUX_HALF    = 10'(`LBPP_AUX_HALF_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  logic                              strobeMeta, strobeSync, strobeLast;
  lbpp_char_type                     dataMeta, dataSync;
  logic                              stopMeta, stopSync;
  logic [4:0]                        ctrl;
  logic [`LBPP_DEV_IRQ_WIDTH-1:0]    irqStatus, irqMask, irqSet, irqClear;
  lbpp_char_type                     fifoMem [0:255];
  logic [7:0]                        wrPtr, rdPtr, printableCount;
  logic [8:0]                        fifoCount, next_fifoCount;
  logic                              lineBusy, fullBusy, formMotion, readValid;
  logic [9:0]                        ackTimer, auxTimer;
  logic [11:0]                       lineTimer;
  logic                              apbAccess, apbWrite, apbRead, cmdWrite;
  logic                              strobeEnd, offline, errBusy, busyNow, onlyOffline;
  logic                              discard, dc1Only, fifoRoom, accept, push, pop;
  logic                              printable, terminator, printBegin;

  // Cable inputs come from another device and are synchronised first.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strobeMeta <= 1'b1;
      strobeSync <= 1'b1;
      strobeLast <= 1'b1;
      dataMeta   <= 8'h00;
      dataSync   <= 8'h00;
      stopMeta   <= 1'b1;
      stopSync   <= 1'b1;
    end else begin
      strobeMeta <= link.strobeN;
      strobeSync <= strobeMeta;
      strobeLast <= strobeSync;
      dataMeta   <= link.data;
      dataSync   <= dataMeta;
      stopMeta   <= link.remoteMotionStopN;
      stopSync   <= stopMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character classification and acceptance.
  // The character is taken at the trailing edge of the strobe, when the data is settled.
  assign strobeEnd   = strobeSync & ~strobeLast;
  assign printable   = dataSync[5] | dataSync[6];
  assign terminator  = (dataSync == `LBPP_CODE_DEL) || (dataSync == `LBPP_CODE_LF) ||
                       (dataSync == `LBPP_CODE_CR) || (dataSync == `LBPP_CODE_VT) ||
                       (dataSync == `LBPP_CODE_FF);
  assign offline     = ~ctrl[`LBPP_CTRL_ONLINE];
  assign errBusy     = ctrl[`LBPP_CTRL_ENC_ERROR] | ctrl[`LBPP_CTRL_PAPER_OUT];
  assign busyNow     = lineBusy | fullBusy | errBusy | offline;
  assign onlyOffline = offline & ~lineBusy & ~fullBusy & ~errBusy;
  assign discard     = ctrl[`LBPP_CTRL_GATED] & busyNow & ~onlyOffline;
  assign dc1Only     = ctrl[`LBPP_CTRL_GATED] & onlyOffline;
  assign fifoRoom    = fifoCount != `LBPP_FIFO_DEPTH;
  assign accept      = strobeEnd & ~discard & (dc1Only | fifoRoom);
  assign push        = accept & ~dc1Only;
  assign apbAccess   = psel & penable & pready;
  assign apbWrite    = apbAccess & pwrite;
  assign apbRead     = apbAccess & ~pwrite;
  assign cmdWrite    = apbWrite && paddr == `LBPP_DEV_CMD;
  assign printBegin  = cmdWrite & pwdata[`LBPP_CMD_PRINT_BEGIN];
  assign pop         = apbRead && paddr == `LBPP_DEV_FIFO && readValid;

  always_comb begin
    next_fifoCount = fifoCount;
    if (push && !pop) begin
      next_fifoCount = fifoCount + 9'h001;
    end else if (pop && !push) begin
      next_fifoCount = fifoCount - 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input FIFO.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifoMem[wrPtr] <= dataSync;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr     <= 8'h00;
      rdPtr     <= 8'h00;
      fifoCount <= 9'h000;
    end else begin
      wrPtr     <= push ? wrPtr + 8'h01 : wrPtr;
      rdPtr     <= pop ? rdPtr + 8'h01 : rdPtr;
      fifoCount <= next_fifoCount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy conditions; a setting event wins over a clearing one in the same cycle.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      printableCount <= 8'h00;
      lineBusy       <= 1'b0;
    end else begin
      if (push && printable) begin
        printableCount <= printBegin ? 8'h01 : printableCount + 8'h01;
      end else if (printBegin) begin
        printableCount <= 8'h00;
      end
      if (push && (terminator || (printable && printableCount == `LBPP_LINE_CHARS - 8'h01))) begin
        lineBusy <= 1'b1;
      end else if (printBegin || (pop && next_fifoCount == 9'h000)) begin
        lineBusy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fullBusy <= 1'b0;
    end else if (next_fifoCount >= `LBPP_FULL_SET) begin
      fullBusy <= 1'b1;
    end else if (next_fifoCount <= `LBPP_FULL_CLEAR) begin
      fullBusy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cable outputs.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ackTimer          <= 10'h000;
      link.ackN         <= 1'b1;
      link.busy         <= 1'b1;
      link.paperOut     <= 1'b0;
      link.onlineSelect <= 1'b0;
      link.faultN       <= 1'b1;
    end else begin
      if (accept) begin
        ackTimer <= ACK_CYCLES;
      end else if (ackTimer != 10'h000) begin
        ackTimer <= ackTimer - 10'h001;
      end
      link.ackN         <= ~(accept || ackTimer > 10'h001);
      link.busy         <= busyNow;
      link.paperOut     <= ctrl[`LBPP_CTRL_PAPER_OUT];
      link.onlineSelect <= ctrl[`LBPP_CTRL_ONLINE];
      link.faultN       <= ~ctrl[`LBPP_CTRL_FAULT];
    end
  end

  // The auxiliary clock runs from reset regardless of link activity.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      auxTimer         <= 10'h000;
      link.auxClockOut <= 1'b0;
    end else if (auxTimer == AUX_HALF - 10'h001) begin
      auxTimer         <= 10'h000;
      link.auxClockOut <= ~link.auxClockOut;
    end else begin
      auxTimer <= auxTimer + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lineTimer      <= 12'h000;
      link.lineCount <= 1'b0;
    end else begin
      if (cmdWrite && pwdata[`LBPP_CMD_LINE_FEED]) begin
        lineTimer <= LINE_CYCLES;
      end else if (lineTimer != 12'h000) begin
        lineTimer <= lineTimer - 12'h001;
      end
      link.lineCount <= (cmdWrite && pwdata[`LBPP_CMD_LINE_FEED]) || lineTimer > 12'h001;
    end
  end

  // The remote stop wins over a start written in the same cycle.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      formMotion <= 1'b0;
    end else if (!stopSync) begin
      formMotion <= 1'b0;
    end else if (cmdWrite && pwdata[`LBPP_CMD_FORM_START]) begin
      formMotion <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt.
  assign irqSet   = {strobeEnd & discard, formMotion & ~stopSync,
                     accept & dc1Only & (dataSync == `LBPP_CODE_DC1), push};
  assign irqClear = (apbWrite && paddr == `LBPP_DEV_IRQ_STATUS) ?
                    pwdata[`LBPP_DEV_IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl      <= 5'h02;
      irqMask   <= '0;
      irqStatus <= '0;
      irq       <= 1'b0;
    end else begin
      if (apbWrite && paddr == `LBPP_DEV_CTRL) begin
        ctrl <= pwdata[4:0];
      end
      if (apbWrite && paddr == `LBPP_DEV_IRQ_MASK) begin
        irqMask <= pwdata[`LBPP_DEV_IRQ_WIDTH-1:0];
      end
      irqStatus <= (irqStatus & ~irqClear) | irqSet;
      irq       <= |(irqStatus & irqMask);
    end
  end

  // Read data is prepared in the setup cycle, so every access takes exactly one access cycle.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      readValid <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        readValid <= fifoCount != 9'h000;
        pslverr   <= 1'b0;
        prdata    <= 32'h0000_0000;
        unique case (paddr)
          `LBPP_DEV_CTRL:       prdata <= {27'h0, ctrl};
          `LBPP_DEV_CMD:        prdata <= 32'h0000_0000;
          `LBPP_DEV_STATUS:     prdata <= {15'h0, fifoCount, 1'b0, onlyOffline, errBusy, fullBusy,
                                           lineBusy, formMotion, fifoCount == 9'h000, busyNow};
          `LBPP_DEV_FIFO:       prdata <= {22'h0, fifoCount != 9'h000,
                                           fifoMem[rdPtr][5] | fifoMem[rdPtr][6], fifoMem[rdPtr]};
          `LBPP_DEV_IRQ_STATUS: prdata <= {28'h0, irqStatus};
          `LBPP_DEV_IRQ_MASK:   prdata <= {28'h0, irqMask};
          default:              pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : lbpp_printer
